//--- logic/jib_consts.vh
`ifndef JIB_CONSTS_VH
`define JIB_CONSTS_VH

// ----------------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------------
`define JIB_IR_WIDTH        4
`define JIB_IR_EXTEST       4'h0
`define JIB_IR_IDCODE       4'h1
`define JIB_IR_SAMPLE       4'h2
`define JIB_IR_BYPASS       4'hF
`define JIB_IR_RESET        4'h1
`define JIB_IR_STATUS       4'h1

// ----------------------------------------------------------------------
// identification register layout
// ----------------------------------------------------------------------
`define JIB_ID_WIDTH        32
`define JIB_ID_VER_MSB      31
`define JIB_ID_VER_LSB      28
`define JIB_ID_PART_MSB     27
`define JIB_ID_PART_LSB     12
`define JIB_ID_MFR_MSB      11
`define JIB_ID_MFR_LSB      1
`define JIB_ID_FIXED_BIT    0
`define JIB_ID_FIXED_VAL    1'b1

// ----------------------------------------------------------------------
// boundary scan register
// ----------------------------------------------------------------------
`define JIB_BSR_WIDTH       127

`endif

//--- logic/jib_tap.v
`timescale 1ns/10ps
// Notes on behaviour
// - four-bit instruction selects operation and data register
// - test-logic-reset loads identification instruction 0001
// - capture-ir loads status pattern ending 01
// - shifted instruction takes effect at update-ir
// - decode extest, idcode, sample, bypass codes
// - test mode drives pins, normal mode untouched
// - extest captures inputs, shifts them out
// - extest update-dr drives pins from loaded values
// - sample captures inputs and core outputs normally
// - sample update-dr copies serial into shadow
// - idcode loads identification value at capture-dr
// - 32-bit id: version, part, maker, fixed
// - bypass gives one tck cycle of delay
// - bypass register loads zero at capture-dr
// - shift one bit per rising tck toward tdo
// - shadow updates on falling tck in update states
// - tdo high impedance after exit1, driven while shifting
// - reset pin or five tms-high cycles reset logic
`include "jib_consts.vh"

module jib_tap #(
  parameter [3:0]  ID_VERSION = 4'h1,      // arbitrary value
  parameter [15:0] ID_PART    = 16'h1234,  // arbitrary value
  parameter [10:0] ID_MAKER   = 11'h155    // arbitrary value
) (
  input  wire                       clk_i,
  input  wire                       sys_rst_i,
  input  wire                       ce_i,
  input  wire                       tck_i,
  input  wire                       tms_i,
  input  wire                       tdi_i,
  input  wire                       trst_n_i,
  input  wire [`JIB_BSR_WIDTH-1:0]  pin_in_i,
  input  wire [`JIB_BSR_WIDTH-1:0]  core_out_i,
  output reg                        tdo_o,
  output reg                        tdo_oe_o,
  output reg  [`JIB_BSR_WIDTH-1:0]  pin_out_o,
  output reg                        test_mode_o,
  output reg  [3:0]                 tap_state_o,
  output reg  [`JIB_IR_WIDTH-1:0]   instr_o
);

  // --------------------------------------------------------------------
  // tap states
  // --------------------------------------------------------------------
  localparam [3:0] S_TLR = 4'h0, S_RTI = 4'h1, S_SDR = 4'h2, S_CDR = 4'h3;
  localparam [3:0] S_SHD = 4'h4, S_E1D = 4'h5, S_PD  = 4'h6, S_E2D = 4'h7;
  localparam [3:0] S_UDR = 4'h8, S_SIR = 4'h9, S_CIR = 4'hA, S_SHI = 4'hB;
  localparam [3:0] S_E1I = 4'hC, S_PI  = 4'hD, S_E2I = 4'hE, S_UIR = 4'hF;

  // next tap state for a given tms level
  function [3:0] tap_next;
    input [3:0] st;
    input       tms;
    begin
      case (st)
        S_TLR:   tap_next = tms ? S_TLR : S_RTI;
        S_RTI:   tap_next = tms ? S_SDR : S_RTI;
        S_SDR:   tap_next = tms ? S_SIR : S_CDR;
        S_CDR:   tap_next = tms ? S_E1D : S_SHD;
        S_SHD:   tap_next = tms ? S_E1D : S_SHD;
        S_E1D:   tap_next = tms ? S_UDR : S_PD;
        S_PD:    tap_next = tms ? S_E2D : S_PD;
        S_E2D:   tap_next = tms ? S_UDR : S_SHD;
        S_UDR:   tap_next = tms ? S_SDR : S_RTI;
        S_SIR:   tap_next = tms ? S_TLR : S_CIR;
        S_CIR:   tap_next = tms ? S_E1I : S_SHI;
        S_SHI:   tap_next = tms ? S_E1I : S_SHI;
        S_E1I:   tap_next = tms ? S_UIR : S_PI;
        S_PI:    tap_next = tms ? S_E2I : S_PI;
        S_E2I:   tap_next = tms ? S_UIR : S_SHI;
        S_UIR:   tap_next = tms ? S_SDR : S_RTI;
        default: tap_next = S_TLR;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  reg [3:0]                 sync1;
  reg [3:0]                 sync2;
  reg                       tck_d;
  reg [`JIB_BSR_WIDTH-1:0]  pin_s1;
  reg [`JIB_BSR_WIDTH-1:0]  pin_s2;

  // second stage only feeds logic; first stage is read by second alone
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync1  <= 4'h0;
      sync2  <= 4'h0;
      tck_d  <= 1'b0;
      pin_s1 <= {`JIB_BSR_WIDTH{1'b0}};
      pin_s2 <= {`JIB_BSR_WIDTH{1'b0}};
    end else if (ce_i) begin
      sync1  <= {trst_n_i, tdi_i, tms_i, tck_i};
      sync2  <= sync1;
      tck_d  <= sync2[0];
      pin_s1 <= pin_in_i;
      pin_s2 <= pin_s1;
    end
  end

  wire tck_rise  = sync2[0] & ~tck_d;
  wire tck_fall  = ~sync2[0] & tck_d;
  wire tms_s     = sync2[1];
  wire tdi_s     = sync2[2];
  wire trst_n_s  = sync2[3];

  // --------------------------------------------------------------------
  // scan registers
  // --------------------------------------------------------------------
  reg [3:0]                 state;
  reg [`JIB_IR_WIDTH-1:0]   ir_shift;
  reg [`JIB_ID_WIDTH-1:0]   id_shift;
  reg                       bypass_bit;
  reg [`JIB_BSR_WIDTH-1:0]  bsr_shift;
  reg [`JIB_BSR_WIDTH-1:0]  bsr_shadow;

  wire [`JIB_ID_WIDTH-1:0] id_value = {ID_VERSION, ID_PART, ID_MAKER, `JIB_ID_FIXED_VAL};

  // instruction decode; invalid codes fall back to bypass
  wire sel_bsr  = (instr_o == `JIB_IR_EXTEST) | (instr_o == `JIB_IR_SAMPLE);
  wire sel_id   = (instr_o == `JIB_IR_IDCODE);
  wire is_ext   = (instr_o == `JIB_IR_EXTEST);
  wire tlr_hold = (state == S_TLR); // test reset acts through the state, so instr resets one clock after state enters S_TLR

  // tap walk and rising-edge capture/shift
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      state      <= S_TLR;
      ir_shift   <= `JIB_IR_RESET;
      id_shift   <= {`JIB_ID_WIDTH{1'b0}};
      bypass_bit <= 1'b0;
      bsr_shift  <= {`JIB_BSR_WIDTH{1'b0}};
    end else if (ce_i) begin
      if (~trst_n_s) begin
        state      <= S_TLR;
        id_shift   <= {`JIB_ID_WIDTH{1'b0}};
        bypass_bit <= 1'b0;
        bsr_shift  <= {`JIB_BSR_WIDTH{1'b0}};
      end else if (tck_rise) begin
        state <= tap_next(state, tms_s);
        case (state)
          S_TLR: begin
            id_shift   <= {`JIB_ID_WIDTH{1'b0}};
            bypass_bit <= 1'b0;
            bsr_shift  <= {`JIB_BSR_WIDTH{1'b0}};
          end
          S_CIR: ir_shift <= `JIB_IR_STATUS;
          S_SHI: ir_shift <= {tdi_s, ir_shift[`JIB_IR_WIDTH-1:1]};
          S_CDR: begin
            if (sel_bsr)
              bsr_shift <= pin_s2 | (is_ext ? {`JIB_BSR_WIDTH{1'b0}} : core_out_i);
            else if (sel_id)
              id_shift <= id_value;
            else
              bypass_bit <= 1'b0;
          end
          S_SHD: begin
            if (sel_bsr)
              bsr_shift <= {tdi_s, bsr_shift[`JIB_BSR_WIDTH-1:1]};
            else if (sel_id)
              id_shift <= {tdi_s, id_shift[`JIB_ID_WIDTH-1:1]};
            else
              bypass_bit <= tdi_s;
          end
          default: ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // falling-edge updates and tdo
  // --------------------------------------------------------------------
  // tdo changes on the falling edge so the tester samples it stably
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      instr_o    <= `JIB_IR_RESET;
      bsr_shadow <= {`JIB_BSR_WIDTH{1'b0}};
      tdo_o      <= 1'b0;
      tdo_oe_o   <= 1'b0;
    end else if (ce_i) begin
      if (tlr_hold) begin
        instr_o    <= `JIB_IR_RESET;
        bsr_shadow <= {`JIB_BSR_WIDTH{1'b0}};
        tdo_oe_o   <= 1'b0;
      end else if (tck_fall) begin
        if (state == S_UIR)
          instr_o <= ir_shift;
        if (state == S_UDR && sel_bsr)
          bsr_shadow <= bsr_shift;
        tdo_oe_o <= (state == S_SHD) | (state == S_SHI);
        if (state == S_SHI)
          tdo_o <= ir_shift[0];
        else if (state == S_SHD)
          tdo_o <= sel_bsr ? bsr_shift[0] : (sel_id ? id_shift[0] : bypass_bit);
      end
    end
  end

  // --------------------------------------------------------------------
  // pin drive and status
  // --------------------------------------------------------------------
  // pins see the shadow only under extest, so preload never disturbs them
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_out_o   <= {`JIB_BSR_WIDTH{1'b0}};
      test_mode_o <= 1'b0;
      tap_state_o <= S_TLR;
    end else if (ce_i) begin
      pin_out_o   <= is_ext ? bsr_shadow : core_out_i;
      test_mode_o <= is_ext;
      tap_state_o <= state;
    end
  end

endmodule // jib_tap

//--- test/jib_tap_monitor.sv
`timescale 1ns/10ps
// ----------------------------------
// port checker
// ----------------------------------
module jib_tap_monitor (
  input wire logic         clk_i,
  input wire logic         sys_rst_i,
  input wire logic [126:0] core_out_i,
  input wire logic         tdo_o,
  input wire logic         tdo_oe_o,
  input wire logic [126:0] pin_out_o,
  input wire logic         test_mode_o,
  input wire logic [3:0]   tap_state_o,
  input wire logic [3:0]   instr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // state entries; the windows below reach 16 and 24 clocks, while one tck lasts 16
  sequence s_tlr_in; $changed(tap_state_o) && tap_state_o == 4'h0; endsequence
  sequence s_exit_in; $changed(tap_state_o) && tap_state_o inside {4'h5, 4'hC}; endsequence
  property p_rst_id; $fell(sys_rst_i) |-> instr_o == 4'h1; endproperty
  a_rst_id: assert property (p_rst_id) else $error("instr not idcode");
  property p_tlr_id; s_tlr_in |-> ##[0:24] instr_o == 4'h1; endproperty
  a_tlr_id: assert property (p_tlr_id) else $error("tlr kept old instr");
  property p_upd; $changed(instr_o) |-> tap_state_o inside {4'h0, 4'hF}; endproperty
  a_upd: assert property (p_upd) else $error("instr moved early");
  // mode may lag the instruction by one clock, hence the stable guard
  property p_mode; $stable(instr_o) |-> test_mode_o == (instr_o == 4'h0); endproperty
  a_mode: assert property (p_mode) else $error("bad mode");
  property p_oe_on; $rose(tdo_oe_o) |-> tap_state_o inside {4'h4, 4'hB}; endproperty
  a_oe_on: assert property (p_oe_on) else $error("tdo driven off shift");
  property p_oe_off; s_exit_in |-> ##[1:16] !tdo_oe_o; endproperty
  a_oe_off: assert property (p_oe_off) else $error("tdo not released");
  property p_tdo; $changed(tdo_o) |-> tap_state_o inside {4'h0, 4'h4, 4'hB}; endproperty
  a_tdo: assert property (p_tdo) else $error("tdo moved off shift");
  property p_pins; !test_mode_o [*3] |-> pin_out_o == $past(core_out_i); endproperty
  a_pins: assert property (p_pins) else $error("pins disturbed");
endmodule // jib_tap_monitor
bind jib_tap jib_tap_monitor jib_tap_monitor_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .core_out_i(core_out_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .pin_out_o(pin_out_o),
  .test_mode_o(test_mode_o), .tap_state_o(tap_state_o), .instr_o(instr_o));

//--- test/jib_tester.sv
`timescale 1ns/10ps
// ----------------------------------
// boundary-scan tester model
// ----------------------------------
module jib_tester (
  input  wire logic clk_i,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o
);
  initial begin
    tck_o = 0;
    tms_o = 1;
    tdi_o = 0;
  end
  // one 64 ns tck; pins move while tck is low, a released tdo reads as z
  task automatic cyc(input logic m, input logic d, output logic b);
    @(negedge clk_i);
    tck_o = 0;
    tms_o = m;
    tdi_o = d;
    repeat (8) @(negedge clk_i);
    tck_o = 1;
    b = tdo_oe_i ? tdo_i : 1'bz;
    repeat (7) @(negedge clk_i);
  endtask
  // idle, scan n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input logic [126:0] d, input int n, output logic [126:0] q);
    logic b;
    q = '0;
    cyc(0, 0, b);
    cyc(1, 0, b);
    if (ir) cyc(1, 0, b);
    cyc(0, 0, b);
    cyc(0, 0, b);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, d[i], b);
      q[i] = b;
    end
    cyc(1, 0, b);
    cyc(0, 0, b);
  endtask
  // one spare high cycle past the five; tlr_hold resets instr with no tck edge
  task automatic tlr;
    logic b;
    repeat (6) cyc(1, 0, b);
  endtask
endmodule // jib_tester

//--- test/tb_jib_tap.sv
`timescale 1ns/10ps
// ----------------------------------
// self-checking bench
// ----------------------------------
module tb_jib_tap;
  localparam logic [3:0]  VER = 4'h3;     // arbitrary value
  localparam logic [15:0] PRT = 16'h0abc; // arbitrary value
  localparam logic [10:0] MKR = 11'h2a5;  // arbitrary value
  logic         clk_i = 0, sys_rst_i = 1, trst_n = 1, tck, tms, tdi, tdo, oe, tmode;
  logic [126:0] pin_in = 0, core_out = 0, pin_out, d, q;
  logic [3:0]   st, instr, c;
  integer       seed = 15631, n_errors = 0, checks = 0;
  always #2 clk_i = ~clk_i;
  jib_tap #(.ID_VERSION(VER), .ID_PART(PRT), .ID_MAKER(MKR)) jib_tap_i (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .ce_i(1'b1), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n),
    .pin_in_i(pin_in), .core_out_i(core_out), .tdo_o(tdo), .tdo_oe_o(oe), .pin_out_o(pin_out),
    .test_mode_o(tmode), .tap_state_o(st), .instr_o(instr));
  jib_tester jib_tester_i (.clk_i(clk_i), .tdo_i(tdo), .tdo_oe_i(oe), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
  function automatic logic [126:0] rnd();
    logic [127:0] r = {$random(seed), $random(seed), $random(seed), $random(seed)};
    return r[126:0];
  endfunction
  // bypass answers with a captured zero, then each tdi bit one tck late
  function automatic logic [126:0] exp_bypass(input logic [126:0] v);
    return 127'({v[30:0], 1'b0});
  endfunction
  task automatic cmp(input logic [126:0] got, input logic [126:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // load an instruction and see its capture, activation and mode
  task automatic set_ir(input logic [3:0] k);
    jib_tester_i.scan(1'b1, 127'(k), 4, q);
    cmp(127'(q[1:0]), 127'h1);
    cmp(127'(instr), 127'(k));
    cmp(127'(tmode), 127'(k == 4'h0));
  endtask
  // a hang ends the run as a failure
  initial begin
    #200000;
    n_errors++;
    summarize;
  end
  initial begin
    repeat (12) @(negedge clk_i);
    sys_rst_i = 0;
    repeat (4) @(negedge clk_i);
    cmp(127'(instr), 127'h1);
    jib_tester_i.scan(1'b0, 127'h0, 32, q);
    cmp(q, 127'({VER, PRT, MKR, 1'b1}));
    // bypass, then invalid codes that fall back to it
    for (int i = 0; i < 3; i++) begin
      c = i == 0 ? 4'hf : 4'(3 + ($unsigned($random(seed)) % 12));
      set_ir(c);
      d = rnd();
      jib_tester_i.scan(1'b0, d, 32, q);
      cmp(q, exp_bypass(d));
    end
    set_ir(4'h2);
    pin_in = rnd();
    core_out = rnd();
    d = rnd();
    jib_tester_i.scan(1'b0, d, 127, q);
    cmp(q, pin_in | core_out);
    cmp(pin_out, core_out);
    set_ir(4'h0);
    cmp(pin_out, d);
    d = rnd();
    jib_tester_i.scan(1'b0, d, 127, q);
    cmp(q, pin_in);
    cmp(pin_out, d);
    trst_n = 0;
    repeat (6) @(negedge clk_i);
    trst_n = 1;
    repeat (6) @(negedge clk_i);
    cmp(127'(instr), 127'h1);
    cmp(pin_out, core_out);
    set_ir(4'hf);
    jib_tester_i.tlr();
    cmp(127'(instr), 127'h1);
    summarize;
  end
endmodule // tb_jib_tap
